// ---- rtl/ncopb_defines.vh ----
// Register offsets, reset values and field positions for the channel B oscillator
// preset bank and the start-up state register. Included by the bank modules.
`ifndef NCOPB_DEFINES_VH
`define NCOPB_DEFINES_VH

`define NCOPB_ADDR_W          12
`define NCOPB_FREQ_P1_OFS     12'h248
`define NCOPB_PHASE_P1_OFS    12'h24c
`define NCOPB_FREQ_P2_OFS     12'h250
`define NCOPB_PHASE_P2_OFS    12'h254
`define NCOPB_FREQ_P3_OFS     12'h258
`define NCOPB_PHASE_P3_OFS    12'h25c
`define NCOPB_PHASE_P0_OFS    12'h244
`define NCOPB_STARTUP_OFS     12'h270
`define NCOPB_PRESET_STRIDE   12'h008
`define NCOPB_PHASE_DELTA     12'h004
`define NCOPB_FREQ_RESET      32'hc0000000
`define NCOPB_PHASE_RESET     16'h0000
`define NCOPB_INIT_DONE_BIT   0
`define NCOPB_INIT_CYCLES     16'h0010

`endif

// ---- rtl/ncopb_init_seq.v ----
// Start-up sequencer: counts a fixed number of clocks after reset and then
// raises the done flag. Assumes ref_clk runs and srst is synchronous.
`timescale 1ns/1ns
`include "ncopb_defines.vh"

module ncopb_init_seq #(
  parameter [15:0] INIT_CYCLES = `NCOPB_INIT_CYCLES
) (
  input  wire ref_clk,  // Register clock
  input  wire srst,     // Synchronous reset, active high
  output reg  done_reg  // Initialization finished
);
  reg [15:0] count_reg;

  always @(posedge ref_clk) begin
    if (srst) begin
      count_reg <= 16'h0000;
      done_reg  <= 1'b0;
    end else if (!done_reg) begin
      if (count_reg == INIT_CYCLES - 16'h0001) begin
        done_reg <= 1'b1;
      end
      count_reg <= count_reg + 16'h0001;
    end
  end
endmodule // ncopb_init_seq

// ---- rtl/ncopb_bank.v ----
// Channel B oscillator preset register bank with start-up state register.
// Assumes the serial configuration port front end presents one-cycle read and
// write strobes with an address on ref_clk; preset selection comes from outside.
`timescale 1ns/1ns
`include "ncopb_defines.vh"

module ncopb_bank #(
  parameter [15:0] INIT_CYCLES = `NCOPB_INIT_CYCLES
) (
  input  wire        ref_clk,        // Register clock, 25 MHz
  input  wire        srst,           // Synchronous reset, active high
  input  wire [11:0] reg_addr,       // Register byte address
  input  wire        reg_wr,         // Write strobe, one cycle
  input  wire        reg_rd,         // Read strobe, one cycle
  input  wire [31:0] reg_wdata,      // Write data
  input  wire [1:0]  preset_sel,     // Active preset from selection logic
  input  wire        single_ch_mode, // Interleaved single-channel mode
  input  wire [31:0] cha_freq,       // Channel A selected frequency word
  input  wire [15:0] cha_phase,      // Channel A selected phase word
  output reg  [31:0] reg_rdata_reg,  // Read data, valid with reg_rvalid_reg
  output reg         reg_rvalid_reg, // Read answer strobe
  output reg  [31:0] chb_freq_reg,   // Frequency word to channel B oscillator
  output reg  [15:0] chb_phase_reg,  // Phase word to channel B oscillator
  output reg         init_done_reg   // Initialization finished
);
  reg  [31:0] chb_freq_preset1;
  reg  [31:0] chb_freq_preset2;
  reg  [31:0] chb_freq_preset3;
  reg  [15:0] chb_phase_preset0;
  reg  [15:0] chb_phase_preset1;
  reg  [15:0] chb_phase_preset2;
  reg  [15:0] chb_phase_preset3;
  reg  [31:0] rdata_next;
  reg  [31:0] sel_freq;
  reg  [15:0] sel_phase;
  wire        seq_done;
  wire [11:0] rel_addr;
  wire [2:0]  freq_dec;
  wire [3:0]  phase_dec;
  wire        status_dec;

  ncopb_init_seq #(
    .INIT_CYCLES (INIT_CYCLES)
  ) u_init_seq (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .done_reg (seq_done)
  );

  // Preset index of a frequency word; preset 0's frequency word lies outside this bank
  function [2:0] freq_hit;
    input [11:0] a;
    begin
      if (a == `NCOPB_FREQ_P1_OFS) begin
        freq_hit = 3'b001;
      end else if (a == `NCOPB_FREQ_P2_OFS) begin
        freq_hit = 3'b010;
      end else if (a == `NCOPB_FREQ_P3_OFS) begin
        freq_hit = 3'b100;
      end else begin
        freq_hit = 3'b000;
      end
    end
  endfunction

  // Phase words are 16 bits wide; the upper half of the read word is zero
  function [31:0] phase_word;
    input [15:0] p;
    begin
      phase_word = {16'h0000, p};
    end
  endfunction

  // Phase word sits one word after the frequency word of its preset
  assign rel_addr = reg_addr - `NCOPB_PHASE_DELTA;

  // One-hot selects shared by the write and read paths, so both always decode alike
  assign freq_dec   = freq_hit(reg_addr);
  assign phase_dec  = {freq_hit(rel_addr), reg_addr == `NCOPB_PHASE_P0_OFS};
  assign status_dec = (reg_addr == `NCOPB_STARTUP_OFS);

  // One flop group per register; the start-up state register has no write path
  always @(posedge ref_clk) begin
    if (srst) begin
      chb_freq_preset1 <= `NCOPB_FREQ_RESET;
    end else if (reg_wr && freq_dec[0]) begin
      chb_freq_preset1 <= reg_wdata;
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      chb_freq_preset2 <= `NCOPB_FREQ_RESET;
    end else if (reg_wr && freq_dec[1]) begin
      chb_freq_preset2 <= reg_wdata;
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      chb_freq_preset3 <= `NCOPB_FREQ_RESET;
    end else if (reg_wr && freq_dec[2]) begin
      chb_freq_preset3 <= reg_wdata;
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      chb_phase_preset0 <= `NCOPB_PHASE_RESET;
    end else if (reg_wr && phase_dec[0]) begin
      chb_phase_preset0 <= reg_wdata[15:0];
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      chb_phase_preset1 <= `NCOPB_PHASE_RESET;
    end else if (reg_wr && phase_dec[1]) begin
      chb_phase_preset1 <= reg_wdata[15:0];
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      chb_phase_preset2 <= `NCOPB_PHASE_RESET;
    end else if (reg_wr && phase_dec[2]) begin
      chb_phase_preset2 <= reg_wdata[15:0];
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      chb_phase_preset3 <= `NCOPB_PHASE_RESET;
    end else if (reg_wr && phase_dec[3]) begin
      chb_phase_preset3 <= reg_wdata[15:0];
    end
  end

  always @* begin
    rdata_next = 32'h00000000;
    if (freq_dec[0]) begin
      rdata_next = chb_freq_preset1;
    end else if (freq_dec[1]) begin
      rdata_next = chb_freq_preset2;
    end else if (freq_dec[2]) begin
      rdata_next = chb_freq_preset3;
    end else if (phase_dec[0]) begin
      rdata_next = phase_word(chb_phase_preset0);
    end else if (phase_dec[1]) begin
      rdata_next = phase_word(chb_phase_preset1);
    end else if (phase_dec[2]) begin
      rdata_next = phase_word(chb_phase_preset2);
    end else if (phase_dec[3]) begin
      rdata_next = phase_word(chb_phase_preset3);
    end else if (status_dec) begin
      // Reserved upper bits read as zero
      rdata_next[`NCOPB_INIT_DONE_BIT] = seq_done;
    end
  end

  // Preset 0 frequency lives in another bank; forward the reset word for it
  always @* begin
    case (preset_sel)
      2'd0: begin
        sel_freq  = `NCOPB_FREQ_RESET;
        sel_phase = chb_phase_preset0;
      end
      2'd1: begin
        sel_freq  = chb_freq_preset1;
        sel_phase = chb_phase_preset1;
      end
      2'd2: begin
        sel_freq  = chb_freq_preset2;
        sel_phase = chb_phase_preset2;
      end
      default: begin
        sel_freq  = chb_freq_preset3;
        sel_phase = chb_phase_preset3;
      end
    endcase
  end

  // Read data holds until the next read so a slow host can still pick it up
  always @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata_reg  <= 32'h00000000;
      reg_rvalid_reg <= 1'b0;
    end else begin
      reg_rvalid_reg <= reg_rd;
      if (reg_rd) begin
        reg_rdata_reg <= rdata_next;
      end
    end
  end

  // Channel B takes channel A whole in single-channel mode, with the same one-clock lag
  always @(posedge ref_clk) begin
    if (srst) begin
      chb_freq_reg  <= `NCOPB_FREQ_RESET;
      chb_phase_reg <= `NCOPB_PHASE_RESET;
    end else if (single_ch_mode) begin
      chb_freq_reg  <= cha_freq;
      chb_phase_reg <= cha_phase;
    end else begin
      chb_freq_reg  <= sel_freq;
      chb_phase_reg <= sel_phase;
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      init_done_reg <= 1'b0;
    end else begin
      init_done_reg <= seq_done;
    end
  end
endmodule // ncopb_bank

// ---- bench/ncopb_chk.sv ----
// Assertions on the preset bank ports.
// Bound to ncopb_bank; one clock, synchronous reset.
`timescale 1ns/1ns
module ncopb_chk (
  input wire        ref_clk, srst, reg_wr, reg_rd, single_ch_mode, init_done_reg, // Bits
  input wire [1:0]  preset_sel, // Preset
  input wire [11:0] reg_addr, // Address
  input wire [15:0] cha_phase, chb_phase_reg, // Phases
  input wire [31:0] reg_wdata, reg_rdata_reg, cha_freq, chb_freq_reg // Words
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_rst; $past(srst) |-> chb_freq_reg == 32'hc0000000 && chb_phase_reg == 16'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_flag; reg_rd && reg_addr == 12'h270 |=> reg_rdata_reg == {31'h0, init_done_reg}; endproperty
  a_flag: assert property (p_flag) else $error("flag");
  property p_hold; init_done_reg |=> init_done_reg; endproperty
  a_hold: assert property (p_hold) else $error("done dropped");
  property p_wr; reg_wr ##1 reg_rd && $stable(reg_addr) && reg_addr == 12'h258
    |=> reg_rdata_reg == $past(reg_wdata, 2); endproperty
  a_wr: assert property (p_wr) else $error("stored");
  property p_mode; !$past(srst) && $past(single_ch_mode)
    |-> chb_freq_reg == $past(cha_freq) && chb_phase_reg == $past(cha_phase); endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_sel; !$past(srst) && !$past(single_ch_mode) && $past(preset_sel) == 2'h0
    |-> chb_freq_reg == 32'hc0000000; endproperty
  a_sel: assert property (p_sel) else $error("preset 0");
  c_mode: cover property (single_ch_mode);
  c_done: cover property ($rose(init_done_reg));
  c_wr: cover property (reg_wr);
endmodule // ncopb_chk
bind ncopb_bank ncopb_chk u_ncopb_chk (.*);

// ---- bench/ncopb_host.sv ----
// Host model: one-cycle strobes set at falling edges.
// Tasks are entered at a falling edge and return at one.
`timescale 1ns/1ns
module ncopb_host (
  input  wire        ref_clk, reg_rvalid_reg, // Clock, valid
  input  wire [31:0] reg_rdata_reg, // Read data
  output reg  [11:0] reg_addr = 12'h0, // Address
  output reg         reg_wr = 1'b0, reg_rd = 1'b0, // Strobes
  output reg  [31:0] reg_wdata = 32'h0 // Write data
);
  task wr(input [11:0] a, input [31:0] d);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge ref_clk) reg_wr = 1'b0;
    @(negedge ref_clk);
  endtask
  task rd(input [11:0] a, output [31:0] d, output v);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge ref_clk) {d, v} = {reg_rdata_reg, reg_rvalid_reg};
    reg_rd = 1'b0;
    @(negedge ref_clk);
  endtask
  task wait_init(output ok);
    reg [31:0] d;
    reg v;
    d = 32'h0;
    for (int i = 0; i < 40 && d[0] !== 1'b1; i++) rd(12'h270, d, v);
    ok = d[0];
  endtask
endmodule // ncopb_host

// ---- bench/ncopb_bank_tb.sv ----
// Self-checking bench for the preset bank.
// Host model drives the register port; the rest changes at falling edges.
`timescale 1ns/1ns
module ncopb_bank_tb;
  logic        ref_clk = 1'b0, srst = 1'b1, single_ch_mode = 1'b0, ok, v;
  logic        reg_wr, reg_rd, reg_rvalid_reg, init_done_reg;
  logic [1:0]  preset_sel = 2'h0;
  logic [11:0] reg_addr, a;
  logic [15:0] cha_phase = 16'h5a5a, chb_phase_reg;
  logic [31:0] cha_freq = 32'h1234abcd, d, reg_wdata, reg_rdata_reg, chb_freq_reg;
  integer      fails = 0, num_checks = 0;
  always #20 ref_clk = ~ref_clk;
  ncopb_bank #(.INIT_CYCLES(16'h0004)) u_ncopb_bank (.*);
  ncopb_host u_ncopb_host (.*);
  task chk(input string n, input [47:0] e, input [47:0] g);
    num_checks++;
    if (g !== e) $display("ERROR %s expected %h seen %h", n, e, g);
    if (g !== e) fails++;
  endtask
  task rdchk(input [31:0] e);
    u_ncopb_host.rd(a, d, v);
    chk("read", {16'h1, e}, {15'h0, v, d});
  endtask
  task conclude;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task t_regs;
    u_ncopb_host.wait_init(ok);
    chk("done", 48'h1, {47'h0, ok});
    if (ok !== 1'b1) conclude;
    for (int i = 0; i < 8; i++) begin
      a = 12'h244 + 12'(4 * i);
      rdchk(i < 7 && i[0] ? 32'hc0000000 : 32'h0);
      u_ncopb_host.wr(a, {20'h9a3c5, a});
      rdchk(i > 6 ? 32'h0 : i[0] ? {20'h9a3c5, a} : {20'h5, a});
    end
    a = 12'h270;
    u_ncopb_host.wr(a, 32'h0);
    rdchk(32'h1);
    $display("t_regs done");
  endtask
  task t_out;
    for (int p = 0; p < 4; p++) begin
      preset_sel = 2'(p);
      repeat (2) @(negedge ref_clk);
      a = 12'h240 + 12'(8 * p);
      chk("osc", {p ? {20'h9a3c5, a} : 32'hc0000000, 4'h5, 12'(a + 4)}, {chb_freq_reg, chb_phase_reg});
    end
    single_ch_mode = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("mode", {cha_freq, cha_phase}, {chb_freq_reg, chb_phase_reg});
    $display("t_out done");
  endtask
  initial begin
    repeat (4) @(negedge ref_clk);
    srst = 1'b0;
    t_regs;
    t_out;
    conclude;
  end
endmodule // ncopb_bank_tb
